// ### rtl/usbe_ctrl.sv
// Purpose: baud rate generation and receiver/transmitter enable control of a serial port
// Assumes: configuration and commands come from logic on core_clk; serial clock pin is async
// Notes: ticks are one-cycle pulses on core_clk, not real clocks
`timescale 1ns/100ps

module usbe_ctrl #(
   parameter int unsigned MCK_DIV = usbe_pkg::MCK_DIV_DEF
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // configuration and commands
   input wire usbe_pkg::usbe_cfg_s cfg,
   input wire usbe_pkg::usbe_cmd_s cmd,
   input wire logic etu_ratio_wr,
   input wire logic [usbe_pkg::ETU_W-1:0] etu_ratio_wdata,
   // character engine status
   input wire logic rx_char_busy,
   input wire logic tx_char_busy,
   input wire logic tx_holding_full,
   input wire logic tx_timeguard_busy,
   // serial clock pin
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   // ticks to the character engines
   output logic sample_tick,
   output logic baud_tick,
   // enable state
   output logic rx_enabled,
   output logic tx_enabled,
   output logic rx_soft_reset,
   output logic tx_soft_reset,
   // ratio and decoded factors
   output logic [usbe_pkg::ETU_W-1:0] etu_sample_ratio,
   output logic [5:0] rate_adjust_value,
   output logic [11:0] clock_factor_value
);

   localparam logic [7:0] PRE_LAST = 8'(MCK_DIV - 1);

   logic [7:0] prescale_q;
   logic sck_meta_q, sck_sync_q, sck_prev_q;
   logic div_tick, ext_edge, src_tick, async_mode, frac_on, div_out, baud_next;
   logic [16:0] div_cnt_q, div_last_w, half_w;
   logic extra_q;
   logic [2:0] frac_acc_q;
   logic sck_hi_q, sck_hi_n_q;
   logic [3:0] ovs_q, ovs_last;
   logic [usbe_pkg::ETU_W-1:0] etu_cnt_q, etu_ratio_q;
   logic sample_q, baud_q;
   logic rx_en_q, rx_stop_q, rx_rst_q;
   logic tx_en_q, tx_stop_q, tx_rst_q, tx_work;
   logic [5:0] adj_q;
   logic [11:0] fac_q;

   // prescaler for the divided master clock source
   always_ff @(posedge core_clk)
   begin
      if (reset || prescale_q == PRE_LAST)
         prescale_q <= 8'h00;
      else
         prescale_q <= prescale_q + 8'h01;
   end
   assign div_tick = (prescale_q == PRE_LAST);

   // two-flop synchroniser and edge detect; pin must be slower than core clock / 4.5
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sck_meta_q <= 1'b0;
         sck_sync_q <= 1'b0;
         sck_prev_q <= 1'b0;
      end
      else
      begin
         sck_meta_q <= sck_in;
         sck_sync_q <= sck_meta_q;
         sck_prev_q <= sck_sync_q;
      end
   end
   assign ext_edge = sck_sync_q & ~sck_prev_q;

   // source selection; value 2 behaves as the divided master clock
   always_comb
   begin
      case (cfg.baud_source_select)
         usbe_pkg::SRC_MCK: src_tick = 1'b1;
         usbe_pkg::SRC_EXT: src_tick = ext_edge;
         default: src_tick = div_tick;
      endcase
   end

   // normal asynchronous mode is the only place fractional division runs
   assign async_mode = ~cfg.sync_mode & ~cfg.smartcard_mode;
   assign frac_on = async_mode & ~cfg.special_mode & (cfg.fraction_field != 3'h0);

   // main divider: period is divisor source ticks, one more when a fraction carry is due
   assign div_last_w = {1'b0, cfg.clock_divisor} - 17'h1 + {16'h0, extra_q};
   assign div_out = (cfg.clock_divisor != 16'h0) & src_tick & (div_cnt_q >= div_last_w);
   always_ff @(posedge core_clk)
   begin
      if (reset || cfg.clock_divisor == 16'h0)
         div_cnt_q <= 17'h0;
      else if (div_out)
         div_cnt_q <= 17'h0;
      else if (src_tick)
         div_cnt_q <= div_cnt_q + 17'h1;
   end

   // fraction accumulator: each carry stretches the next period by one source tick
   always_ff @(posedge core_clk)
   begin
      if (reset || !frac_on)
      begin
         frac_acc_q <= 3'h0;
         extra_q <= 1'b0;
      end
      else if (div_out)
      begin
         {extra_q, frac_acc_q} <= {1'b0, frac_acc_q} + {1'b0, cfg.fraction_field};
      end
   end

   // serial clock phase: high for the first half of each divider period
   assign half_w = ({1'b0, cfg.clock_divisor} + 17'h1) >> 1;
   always_ff @(posedge core_clk)
   begin
      if (reset)
         sck_hi_q <= 1'b0;
      else
         sck_hi_q <= (div_cnt_q < half_w);
   end

   // half-cycle copy trims an odd high phase by half a clock to reach 50:50, with the master clock as source only
   always_ff @(negedge core_clk)
   begin
      if (reset)
         sck_hi_n_q <= 1'b0;
      else
         sck_hi_n_q <= sck_hi_q;
   end

   // pin drive; a divisor of 1 cannot be shown on the pin at one-cycle resolution
   always_comb
   begin
      if (cfg.clock_divisor[0] && cfg.baud_source_select == usbe_pkg::SRC_MCK)
         sck_out = sck_hi_q & sck_hi_n_q;
      else
         sck_out = sck_hi_q;
      sck_oe = (cfg.sync_mode & ~cfg.smartcard_mode
                & (cfg.baud_source_select != usbe_pkg::SRC_EXT))
               | (cfg.smartcard_mode & cfg.smartcard_clock_output);
   end

   // oversampling counter for asynchronous mode
   assign ovs_last = cfg.oversample_8 ? usbe_pkg::OVS8_LAST : usbe_pkg::OVS16_LAST;
   always_ff @(posedge core_clk)
   begin
      if (reset || !async_mode)
         ovs_q <= 4'h0;
      else if (div_out)
         ovs_q <= (ovs_q >= ovs_last) ? 4'h0 : ovs_q + 4'h1;
   end

   // elementary time unit ratio register
   always_ff @(posedge core_clk)
   begin
      if (reset)
         etu_ratio_q <= usbe_pkg::ETU_RATIO_RST;
      else if (etu_ratio_wr)
         etu_ratio_q <= etu_ratio_wdata;
   end

   // sampling divider on the card clock; a ratio of zero gives no bit clock
   always_ff @(posedge core_clk)
   begin
      if (reset || !cfg.smartcard_mode || etu_ratio_q == 11'h0)
         etu_cnt_q <= 11'h000;
      else if (div_out)
         etu_cnt_q <= (etu_cnt_q >= etu_ratio_q - 11'h1) ? 11'h000 : etu_cnt_q + 11'h1;
   end

   // baud tick per mode
   always_comb
   begin
      if (cfg.smartcard_mode)
         baud_next = div_out & (etu_ratio_q != 11'h0)
                     & (etu_cnt_q >= etu_ratio_q - 11'h1);
      else if (cfg.sync_mode && cfg.baud_source_select == usbe_pkg::SRC_EXT)
         baud_next = ext_edge;
      else if (cfg.sync_mode)
         baud_next = div_out;
      else
         baud_next = div_out & (ovs_q >= ovs_last);
   end

   // registered tick outputs
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         sample_q <= 1'b0;
         baud_q <= 1'b0;
      end
      else
      begin
         sample_q <= (cfg.sync_mode && !cfg.smartcard_mode) ? baud_next : div_out;
         baud_q <= baud_next;
      end
   end

   // receiver enable: reset command beats disable, disable beats enable
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rx_en_q <= 1'b0;
         rx_stop_q <= 1'b0;
         rx_rst_q <= 1'b0;
      end
      else
      begin
         rx_rst_q <= cmd.receiver_reset_cmd;
         if (cmd.receiver_reset_cmd)
         begin
            rx_en_q <= 1'b0;
            rx_stop_q <= 1'b0;
         end
         else if (cmd.receiver_off_cmd)
            rx_stop_q <= rx_en_q;
         else if (cmd.receiver_on_cmd)
         begin
            rx_en_q <= 1'b1;
            rx_stop_q <= 1'b0;
         end
         else if (rx_stop_q && !rx_char_busy)
         begin
            rx_en_q <= 1'b0;
            rx_stop_q <= 1'b0;
         end
      end
   end

   // transmitter is busy until both characters and any timeguard are done
   assign tx_work = tx_char_busy | tx_holding_full | tx_timeguard_busy;

   // transmitter enable, same priority as the receiver
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         tx_en_q <= 1'b0;
         tx_stop_q <= 1'b0;
         tx_rst_q <= 1'b0;
      end
      else
      begin
         tx_rst_q <= cmd.transmitter_reset_cmd;
         if (cmd.transmitter_reset_cmd)
         begin
            tx_en_q <= 1'b0;
            tx_stop_q <= 1'b0;
         end
         else if (cmd.transmitter_off_cmd)
            tx_stop_q <= tx_en_q;
         else if (cmd.transmitter_on_cmd)
         begin
            tx_en_q <= 1'b1;
            tx_stop_q <= 1'b0;
         end
         else if (tx_stop_q && !tx_work)
         begin
            tx_en_q <= 1'b0;
            tx_stop_q <= 1'b0;
         end
      end
   end

   // decoded smart-card factors, registered for the data outputs
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         adj_q <= 6'h00;
         fac_q <= 12'h000;
      end
      else
      begin
         adj_q <= usbe_pkg::rate_adjust_value(cfg.rate_adjust_code);
         fac_q <= usbe_pkg::clock_factor_value(cfg.clock_factor_code);
      end
   end

   // outputs
   assign sample_tick = sample_q;
   assign baud_tick = baud_q;
   assign rx_enabled = rx_en_q;
   assign tx_enabled = tx_en_q;
   assign rx_soft_reset = rx_rst_q;
   assign tx_soft_reset = tx_rst_q;
   assign etu_sample_ratio = etu_ratio_q;
   assign rate_adjust_value = adj_q;
   assign clock_factor_value = fac_q;

   // checking helpers: measure tick spacing while the setup holds still
   usbe_pkg::usbe_cfg_s cfg_q;
   logic cfg_chg, meas_ok_q, gap_ok_q;
   logic [11:0] tick_cnt_q;
   logic [16:0] gap_q;
   assign cfg_chg = (cfg != cfg_q) | etu_ratio_wr;
   always_ff @(posedge core_clk)
   begin
      cfg_q <= cfg;
      if (reset || cfg_chg)
      begin
         meas_ok_q <= 1'b0;
         gap_ok_q <= 1'b0;
         tick_cnt_q <= 12'h000;
         gap_q <= 17'h0;
      end
      else
      begin
         if (baud_next)
            meas_ok_q <= 1'b1;
         if (div_out)
            gap_ok_q <= 1'b1;
         tick_cnt_q <= baud_next ? 12'h000 : tick_cnt_q + {11'h0, div_out};
         gap_q <= div_out ? 17'h0 : gap_q + 17'h1;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence tx_busy_s;
      tx_enabled && tx_work && !cmd.transmitter_reset_cmd;
   endsequence
   sequence tx_drain_s;
      tx_stop_q && !tx_work && !cmd.transmitter_off_cmd && !cmd.transmitter_on_cmd
         && !cmd.transmitter_reset_cmd;
   endsequence

   ovs_ratio_a: assert property (async_mode && meas_ok_q && baud_next
      |-> tick_cnt_q + 12'h1 == (cfg.oversample_8 ? 12'h008 : 12'h010))
      else $error("async oversampling ratio wrong");
   frac_gap_a: assert property (frac_on && gap_ok_q && div_out
      && cfg.baud_source_select == usbe_pkg::SRC_MCK
      |-> (gap_q + 17'h1 == {1'b0, cfg.clock_divisor})
          || (gap_q == {1'b0, cfg.clock_divisor}))
      else $error("fractional period outside divisor or divisor plus one");
   sync_div_a: assert property (cfg.sync_mode && !cfg.smartcard_mode && div_out
      && cfg.baud_source_select != usbe_pkg::SRC_EXT |=> baud_tick && sample_tick)
      else $error("sync baud tick missing after divider output");
   ext_pass_a: assert property (cfg.sync_mode && !cfg.smartcard_mode && ext_edge
      && cfg.baud_source_select == usbe_pkg::SRC_EXT |=> baud_tick)
      else $error("external clock edge not passed through");
   cd_zero_a: assert property (cfg.clock_divisor == 16'h0
      && !(cfg.sync_mode && cfg.baud_source_select == usbe_pkg::SRC_EXT) |=> !sample_tick)
      else $error("tick produced with zero divisor");
   sck_pin_a: assert property (cfg.smartcard_mode && cfg.smartcard_clock_output
      |-> sck_oe) else $error("card clock not driven on pin");
   sck_half_a: assert property ($rose(sck_hi_q) && cfg.clock_divisor == 16'h4
      && cfg.baud_source_select == usbe_pkg::SRC_MCK && !cfg_chg
      |-> sck_hi_q [*2] ##1 !sck_hi_q) else $error("serial clock duty not 50:50");
   etu_ratio_a: assert property (cfg.smartcard_mode && meas_ok_q && baud_next
      |-> tick_cnt_q + 12'h1 == {1'b0, etu_ratio_q})
      else $error("bit clock ratio does not match programmed ratio");
   etu_reset_a: assert property ($fell(reset) |-> etu_sample_ratio == 11'h174)
      else $error("ratio reset value wrong");
   adjust_map_a: assert property (cfg.rate_adjust_code == 4'h8
      |=> rate_adjust_value == 6'h0c) else $error("adjust code 8 not mapped to 12");
   factor_map_a: assert property (cfg.clock_factor_code == 4'hd
      |=> clock_factor_value == 12'h800) else $error("factor code d not mapped to 2048");
   rx_idle_a: assert property (!rx_enabled && !cmd.receiver_on_cmd |=> !rx_enabled)
      else $error("receiver enabled without command");
   tx_idle_a: assert property (!tx_enabled && !cmd.transmitter_on_cmd
      |=> !tx_enabled) else $error("transmitter enabled without command");
   both_on_a: assert property (cmd.receiver_on_cmd && cmd.transmitter_on_cmd
      && !cmd.receiver_off_cmd && !cmd.transmitter_off_cmd && !cmd.receiver_reset_cmd
      && !cmd.transmitter_reset_cmd |=> rx_enabled && tx_enabled)
      else $error("joint enable failed");
   soft_reset_a: assert property (cmd.receiver_reset_cmd |=> !rx_enabled && rx_soft_reset)
      else $error("receiver reset did not stop at once");
   rx_finish_a: assert property (rx_enabled && rx_char_busy
      && !cmd.receiver_reset_cmd |=> rx_enabled) else $error("receiver stopped mid-character");
   tx_finish_a: assert property (tx_busy_s |=> tx_enabled)
      else $error("transmitter stopped with work pending");
   tx_stop_a: assert property (tx_drain_s |=> !tx_enabled)
      else $error("transmitter did not stop after draining");

endmodule : usbe_ctrl

// ### rtl/usbe_pkg.sv
// Purpose: shared constants, carriers and code tables of the baud and enable control block
// Assumes: one 50 MHz core clock, synchronous active-high reset
// Notes: decode tables return zero for codes that have no assigned factor
package usbe_pkg;

   // field widths
   localparam int CD_W = 16;
   localparam int ETU_W = 11;
   localparam int FRAC_W = 3;

   // clock source selections
   localparam logic [1:0] SRC_MCK = 2'h0;
   localparam logic [1:0] SRC_DIV = 2'h1;
   localparam logic [1:0] SRC_EXT = 2'h3;

   // prescaler ratio of the divided master clock source
   localparam int MCK_DIV_DEF = 8;

   // last count of the oversampling counter (16 and 8 samples per bit)
   localparam logic [3:0] OVS16_LAST = 4'hf;
   localparam logic [3:0] OVS8_LAST = 4'h7;

   // reset value of the elementary time unit ratio
   localparam logic [ETU_W-1:0] ETU_RATIO_RST = 11'h174;

   // static configuration
   typedef struct packed {
      logic sync_mode;
      logic smartcard_mode;
      logic special_mode;
      logic oversample_8;
      logic [1:0] baud_source_select;
      logic [CD_W-1:0] clock_divisor;
      logic [FRAC_W-1:0] fraction_field;
      logic smartcard_clock_output;
      logic [3:0] rate_adjust_code;
      logic [3:0] clock_factor_code;
   } usbe_cfg_s;

   // one-cycle control commands
   typedef struct packed {
      logic receiver_on_cmd;
      logic receiver_off_cmd;
      logic receiver_reset_cmd;
      logic transmitter_on_cmd;
      logic transmitter_off_cmd;
      logic transmitter_reset_cmd;
   } usbe_cmd_s;

   // rate adjustment code to factor
   function automatic logic [5:0] rate_adjust_value(input logic [3:0] code);
      case (code)
         4'h1: rate_adjust_value = 6'h01;
         4'h2: rate_adjust_value = 6'h02;
         4'h3: rate_adjust_value = 6'h04;
         4'h4: rate_adjust_value = 6'h08;
         4'h5: rate_adjust_value = 6'h10;
         4'h6: rate_adjust_value = 6'h20;
         4'h8: rate_adjust_value = 6'h0c;
         4'h9: rate_adjust_value = 6'h14;
         default: rate_adjust_value = 6'h00;
      endcase
   endfunction : rate_adjust_value

   // clock factor code to division factor
   function automatic logic [11:0] clock_factor_value(input logic [3:0] code);
      case (code)
         4'h0: clock_factor_value = 12'h174;
         4'h1: clock_factor_value = 12'h174;
         4'h2: clock_factor_value = 12'h22e;
         4'h3: clock_factor_value = 12'h2e8;
         4'h4: clock_factor_value = 12'h45c;
         4'h5: clock_factor_value = 12'h5d0;
         4'h6: clock_factor_value = 12'h744;
         4'h9: clock_factor_value = 12'h200;
         4'ha: clock_factor_value = 12'h300;
         4'hb: clock_factor_value = 12'h400;
         4'hc: clock_factor_value = 12'h600;
         4'hd: clock_factor_value = 12'h800;
         default: clock_factor_value = 12'h000;
      endcase
   endfunction : clock_factor_value

endpackage : usbe_pkg

// ### bench/usbe_peer.sv
// Purpose: remote device that feeds an external clock onto the serial clock pin
// Assumes: edges are placed with the core clock; the pin has a pull-up
// Notes: the line is released between bursts, so the pull-up takes it
`timescale 1ns/100ps

module usbe_peer (
   // clock
   input wire logic core_clk,
   // burst control from the bench
   input wire logic run,
   input wire logic [7:0] half,
   // serial clock pin drive
   output logic drv,
   output logic oe
);
   logic [7:0] cnt_q;

   // toggle every half period; a half of 5 or more keeps the pin far below core rate
   always_ff @(posedge core_clk)
   begin
      if (!run)
      begin
         cnt_q <= 8'h00;
         drv <= 1'b0;
      end
      else if (cnt_q == half - 8'h01)
      begin
         cnt_q <= 8'h00;
         drv <= ~drv;
      end
      else
         cnt_q <= cnt_q + 8'h01;
   end

   // drive only within a burst
   assign oe = run;
endmodule : usbe_peer

// ### bench/usbe_ctrl_tb_top.sv
// Purpose: self-checking bench of the baud and enable control block
// Assumes: inputs change at the falling edge; outputs sampled there
// Notes: tick periods are counted in core clock cycles
`timescale 1ns/100ps

module usbe_ctrl_tb_top;
   localparam int MDIV = 8;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   usbe_pkg::usbe_cfg_s cfg = '0;
   usbe_pkg::usbe_cmd_s cmd = '0;
   usbe_pkg::usbe_cmd_s c;
   logic etu_ratio_wr = 1'b0;
   logic [10:0] etu_ratio_wdata = 11'h000;
   logic rx_char_busy = 1'b0, tx_char_busy = 1'b0;
   logic tx_holding_full = 1'b0, tx_timeguard_busy = 1'b0;
   logic run = 1'b0;
   logic peer_drv, peer_oe, sck_in, sck_out, sck_oe, sample_tick, baud_tick;
   logic rx_enabled, tx_enabled, rx_soft_reset, tx_soft_reset;
   logic [10:0] etu_sample_ratio;
   logic [5:0] rate_adjust_value;
   logic [11:0] clock_factor_value;
   int errors = 0;
   int total_checks = 0;
   int p;
   int ra[16] = '{0, 1, 2, 4, 8, 16, 32, 0, 12, 20, 0, 0, 0, 0, 0, 0};
   int cf[16] = '{372, 372, 558, 744, 1116, 1488, 1860, 0, 0, 512, 768, 1024, 1536,
      2048, 0, 0};
   // async rows: divisor, fraction, x8, special, baud period; all exact rates
   int at[6][5] = '{'{3, 0, 0, 0, 48}, '{3, 0, 1, 0, 24}, '{2, 3, 1, 0, 19},
      '{2, 3, 0, 0, 38}, '{2, 3, 1, 1, 16}, '{1, 0, 1, 0, 8}};

   always #10 core_clk = ~core_clk;

   // pin level: block, else peer, else pull-up
   assign sck_in = sck_oe ? sck_out : (peer_oe ? peer_drv : 1'b1);

   usbe_peer peer (.core_clk(core_clk), .run(run), .half(8'h06), .drv(peer_drv),
      .oe(peer_oe));

   usbe_ctrl #(.MCK_DIV(MDIV)) dut (.core_clk(core_clk), .reset(reset), .cfg(cfg),
      .cmd(cmd), .etu_ratio_wr(etu_ratio_wr), .etu_ratio_wdata(etu_ratio_wdata),
      .rx_char_busy(rx_char_busy), .tx_char_busy(tx_char_busy),
      .tx_holding_full(tx_holding_full), .tx_timeguard_busy(tx_timeguard_busy),
      .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sample_tick(sample_tick),
      .baud_tick(baud_tick), .rx_enabled(rx_enabled), .tx_enabled(tx_enabled),
      .rx_soft_reset(rx_soft_reset), .tx_soft_reset(tx_soft_reset),
      .etu_sample_ratio(etu_sample_ratio), .rate_adjust_value(rate_adjust_value),
      .clock_factor_value(clock_factor_value));

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick

   // one-cycle command pulse, taken at the rising edge in between
   task automatic pulse(input usbe_pkg::usbe_cmd_s k);
      cmd = k;
      tick(1);
      cmd = '0;
   endtask : pulse

   // cycles between ticks; the first two intervals after a change are skipped
   task automatic period(input bit sel, output int q);
      int n;
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            tick(1);
            n++;
         end while (!(sel ? sample_tick : baud_tick) && n < 5000);
         if (n >= 5000)
         begin
            errors++;
            stop_test();
         end
         q = n;
      end
   endtask : period

   task automatic t_codes();
      for (int k = 0; k < 16; k++)
      begin
         cfg.rate_adjust_code = k[3:0];
         cfg.clock_factor_code = k[3:0];
         tick(2);
         check(rate_adjust_value, ra[k]);
         check(clock_factor_value, cf[k]);
      end
   endtask : t_codes

   task automatic t_enable();
      c = '0;
      c.receiver_on_cmd = 1'b1;
      pulse(c);
      check({rx_enabled, tx_enabled}, 2'h2);
      c = '0;
      c.transmitter_on_cmd = 1'b1;
      pulse(c);
      check(tx_enabled, 1);
      // disable while busy waits for the character
      rx_char_busy = 1'b1;
      c = '0;
      c.receiver_off_cmd = 1'b1;
      pulse(c);
      tick(4);
      check(rx_enabled, 1);
      rx_char_busy = 1'b0;
      tick(1);
      check(rx_enabled, 0);
      {tx_char_busy, tx_holding_full, tx_timeguard_busy} = 3'h7;
      c = '0;
      c.transmitter_off_cmd = 1'b1;
      pulse(c);
      tick(3);
      tx_char_busy = 1'b0;
      tick(2);
      check(tx_enabled, 1);
      tx_holding_full = 1'b0;
      tick(2);
      check(tx_enabled, 1);
      tx_timeguard_busy = 1'b0;
      tick(1);
      check(tx_enabled, 0);
      c = '0;
      c.receiver_on_cmd = 1'b1;
      c.transmitter_on_cmd = 1'b1;
      pulse(c);
      check({rx_enabled, tx_enabled}, 2'h3);
      // side reset cuts a busy side at once, the other side untouched
      tx_char_busy = 1'b1;
      c = '0;
      c.transmitter_reset_cmd = 1'b1;
      pulse(c);
      check({rx_enabled, tx_enabled, tx_soft_reset}, 3'h5);
      tick(1);
      check(tx_soft_reset, 0);
      tx_char_busy = 1'b0;
      rx_char_busy = 1'b1;
      c = '0;
      c.receiver_reset_cmd = 1'b1;
      pulse(c);
      check({rx_enabled, rx_soft_reset}, 2'h1);
      rx_char_busy = 1'b0;
   endtask : t_enable

   task automatic t_async();
      int n;
      n = 0;
      repeat (100)
      begin
         tick(1);
         n += sample_tick;
      end
      check(n, 0);
      for (int k = 0; k < 6; k++)
      begin
         cfg.clock_divisor = at[k][0][15:0];
         cfg.fraction_field = at[k][1][2:0];
         cfg.oversample_8 = at[k][2][0];
         cfg.special_mode = at[k][3][0];
         period(1'b0, p);
         check(p, at[k][4]);
      end
      cfg.special_mode = 1'b0;
      cfg.fraction_field = 3'h0;
   endtask : t_async

   task automatic t_sync();
      int hi;
      hi = 0;
      cfg.sync_mode = 1'b1;
      cfg.clock_divisor = 16'h0005;
      period(1'b0, p);
      check(p, 5);
      // half-cycle samples over one odd-divisor period
      repeat (10)
      begin
         @(core_clk);
         #1 hi += sck_out;
      end
      tick(1);
      check({sck_oe, hi[7:0]}, 9'h105);
      // even divisor gives the duty assertion a period to watch
      cfg.clock_divisor = 16'h0004;
      period(1'b0, p);
      check(p, 4);
      cfg.baud_source_select = 2'h1;
      cfg.clock_divisor = 16'h0002;
      period(1'b0, p);
      check(p, 2 * MDIV);
      cfg.baud_source_select = 2'h3;
      cfg.clock_divisor = 16'h0000;
      run = 1'b1;
      period(1'b0, p);
      check({sck_oe, p[7:0]}, 9'h00c);
      run = 1'b0;
      cfg.baud_source_select = 2'h0;
      cfg.sync_mode = 1'b0;
   endtask : t_sync

   task automatic t_card();
      cfg.smartcard_mode = 1'b1;
      cfg.smartcard_clock_output = 1'b1;
      cfg.clock_divisor = 16'h0001;
      etu_ratio_wdata = 11'h7ff;
      etu_ratio_wr = 1'b1;
      tick(1);
      etu_ratio_wr = 1'b0;
      period(1'b0, p);
      check(p, 2047);
      cfg.clock_divisor = 16'h0002;
      etu_ratio_wdata = 11'h005; // nearest integer ratio
      etu_ratio_wr = 1'b1;
      tick(1);
      etu_ratio_wr = 1'b0;
      check(etu_sample_ratio, 11'h005);
      period(1'b1, p);
      check({sck_oe, p[7:0]}, 9'h102);
      period(1'b0, p);
      check(p, 10);
      cfg.smartcard_clock_output = 1'b0;
      tick(1);
      check(sck_oe, 0);
   endtask : t_card

   initial
   begin
      tick(10);
      reset = 1'b0;
      tick(1);
      check(etu_sample_ratio, 11'h174);
      check({rx_enabled, tx_enabled, baud_tick, sck_out}, 4'h0);
      t_codes();
      t_enable();
      t_async();
      t_sync();
      t_card();
      stop_test();
   end
endmodule : usbe_ctrl_tb_top
